// ===== mpub_delay.sv
/*
 * Qualifying delay: output rises once the condition has held for the programmed
 * number of millisecond ticks; restarts from zero whenever the condition drops.
 * Assumes a one-cycle tick pulse from a shared timebase.
 */
`timescale 1ns/1ps
module mpub_delay #(
	parameter int W = 16
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic tick,
	// Condition
	input wire logic cond,
	input wire logic [W-1:0] delay_ms,
	output logic done
);
	import mpub_pkg::*;

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} mpub_dly_type;

	mpub_dly_type st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (!cond) begin
			nxt_st.cnt = '0;
			nxt_st.done = 1'b0;
		end else if (delay_ms == '0) begin
			nxt_st.done = 1'b1;
		end else if (tick && !st_ff.done) begin
			// One spare tick so a partial first tick never shortens the delay
			if (st_ff.cnt >= delay_ms) begin
				nxt_st.done = 1'b1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	assign done = st_ff.done;
endmodule

// ===== mpub_pkg.sv
/*
 * Package for the unbalance, thermal, breaker failure and ground protection block.
 * Assumes a single 40 MHz system clock and current magnitudes in one common unit.
 */
// Function
// - No unbalance detection below 30% rated load
// - Unbalance divides by mean or rated load
// - Deviation from phase farthest from mean
// - Alarm path mirrors trip with own pickup
// - Unbalance over pickup for delay drives relay
// - Thermal capacity over level alarms at once
// - Breaker failure assignment selects relays, message
// - Breaker failure needs trip and mean at or over pickup
// - Breaker failure output after pickup delay
// - Breaker failure held for dropout delay
// - Ground trip drives selected relays and indicators
// - Ground trip when ground current reaches pickup
// - On-start ground delay until start/run decided
package mpub_pkg;

	// ------------------------------------------------------------
	// Widths and timebase
	// ------------------------------------------------------------
	localparam int CUR_W = 16;
	localparam int DLY_W = 16;
	localparam int PCT_W = 8;
	localparam int CLK_HZ = 40000000;
	localparam int TICK_MS = 1;
	localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
	localparam int LIGHT_LOAD_PCT = 30;
	localparam int PCT_FULL = 100;
	localparam int UNB_W = 32;

	// ------------------------------------------------------------
	// Breaker failure assignment, motor state and message codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MPUB_BF_OFF = 2'b00,
		MPUB_BF_ALARM = 2'b01,
		MPUB_BF_AUX = 2'b10,
		MPUB_BF_ALARM_AUX = 2'b11
	} mpub_bf_type;

	typedef enum logic [1:0] {
		MPUB_MS_STOPPED = 2'b00,
		MPUB_MS_UNDECIDED = 2'b01,
		MPUB_MS_STARTING = 2'b10,
		MPUB_MS_RUNNING = 2'b11
	} mpub_motor_type;

	localparam int MSG_W = 6;
	localparam logic [MSG_W-1:0] MSG_UNB_TRIP = 6'h01;
	localparam logic [MSG_W-1:0] MSG_UNB_ALARM = 6'h02;
	localparam logic [MSG_W-1:0] MSG_TC_ALARM = 6'h04;
	localparam logic [MSG_W-1:0] MSG_BF_ALARM = 6'h08;
	localparam logic [MSG_W-1:0] MSG_GND_TRIP = 6'h10;
	localparam logic [MSG_W-1:0] MSG_GND_ALARM = 6'h20;

endpackage

// ===== mpub_protect.sv
/*
 * Top of the motor protection block: unbalance trip/alarm, thermal capacity alarm,
 * breaker failure and ground trip/alarm, driving relays, indicators and messages.
 * Assumes currents and setpoints are synchronous to clk_sys and refreshed per period.
 */
`timescale 1ns/1ps
module mpub_protect (
	// Clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic ce,
	// Measured currents and rated load setting
	input wire logic [mpub_pkg::CUR_W-1:0] phase_a_cur,
	input wire logic [mpub_pkg::CUR_W-1:0] phase_b_cur,
	input wire logic [mpub_pkg::CUR_W-1:0] phase_c_cur,
	input wire logic [mpub_pkg::CUR_W-1:0] ground_cur,
	input wire logic [mpub_pkg::CUR_W-1:0] rated_load_current_setting,
	// Unbalance setpoints
	input wire logic unb_trip_en,
	input wire logic unb_alarm_en,
	input wire logic [mpub_pkg::PCT_W-1:0] unb_trip_pickup_pct,
	input wire logic [mpub_pkg::PCT_W-1:0] unb_alarm_pickup_pct,
	input wire logic [mpub_pkg::DLY_W-1:0] unb_delay_ms,
	// Thermal capacity
	input wire logic [mpub_pkg::PCT_W-1:0] tc_used_pct,
	input wire logic [mpub_pkg::PCT_W-1:0] tc_alarm_level_pct,
	input wire logic tc_alarm_en,
	// Breaker failure
	input wire mpub_pkg::mpub_bf_type bf_assign,
	input wire logic trip_active,
	input wire logic [mpub_pkg::CUR_W-1:0] bf_pickup,
	input wire logic [mpub_pkg::DLY_W-1:0] bf_pickup_delay_ms,
	input wire logic [mpub_pkg::DLY_W-1:0] bf_dropout_delay_ms,
	// Ground
	input wire logic gnd_trip_en,
	input wire logic gnd_alarm_en,
	input wire logic [1:0] gnd_trip_relays,
	input wire logic [mpub_pkg::CUR_W-1:0] gnd_trip_pickup,
	input wire logic [mpub_pkg::CUR_W-1:0] gnd_alarm_pickup,
	input wire logic [mpub_pkg::DLY_W-1:0] gnd_trip_dly_start_ms,
	input wire logic [mpub_pkg::DLY_W-1:0] gnd_trip_dly_run_ms,
	input wire logic [mpub_pkg::DLY_W-1:0] gnd_alarm_dly_start_ms,
	input wire logic [mpub_pkg::DLY_W-1:0] gnd_alarm_dly_run_ms,
	input wire mpub_pkg::mpub_motor_type motor_state,
	// Outputs
	output logic trip_relay,
	output logic alarm_relay,
	output logic aux_relay,
	output logic trip_led,
	output logic aux_led,
	output logic [mpub_pkg::MSG_W-1:0] msg_sel,
	output logic [mpub_pkg::UNB_W-1:0] unbalance_pct
);
	import mpub_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] tick_cnt;
		logic tick;
		logic [CUR_W+1:0] mean3;
		logic [CUR_W-1:0] dev;
		logic unb_armed;
		logic [UNB_W-1:0] unb_num;
		logic [CUR_W+1:0] unb_den;
		logic [UNB_W-1:0] unb_quo;
		logic [UNB_W-1:0] unb_rem;
		logic [5:0] div_step;
		logic [UNB_W-1:0] unb_pct;
		logic bf_out;
		logic [DLY_W-1:0] bf_drop_cnt;
		logic trip_relay;
		logic alarm_relay;
		logic aux_relay;
		logic trip_led;
		logic aux_led;
		logic [MSG_W-1:0] msg;
	} mpub_state_type;

	mpub_state_type st_ff, nxt_st;

	logic [CUR_W-1:0] mean_phase_current;
	logic [CUR_W-1:0] da, db, dc;
	logic unb_trip_cond, unb_alarm_cond, unb_trip_q, unb_alarm_q;
	logic bf_cond, bf_pick_q;
	logic gnd_trip_cond, gnd_alarm_cond, gnd_trip_q, gnd_alarm_q;
	logic use_start_dly;
	logic [DLY_W-1:0] gnd_trip_dly, gnd_alarm_dly;
	logic tc_alarm;
	logic [UNB_W-1:0] unb_sum;

	assign mean_phase_current = st_ff.mean3[CUR_W-1:0];

	function automatic logic [CUR_W-1:0] absdiff(input logic [CUR_W-1:0] x,
		input logic [CUR_W-1:0] y);
		absdiff = (x >= y) ? (x - y) : (y - x);
	endfunction

	always_comb begin
		da = absdiff(phase_a_cur, mean_phase_current);
		db = absdiff(phase_b_cur, mean_phase_current);
		dc = absdiff(phase_c_cur, mean_phase_current);
	end

	// ------------------------------------------------------------
	// Delay qualifiers
	// ------------------------------------------------------------
	// Starting delay also covers the undecided window after current appears
	assign use_start_dly = (motor_state != MPUB_MS_RUNNING);
	assign gnd_trip_dly = use_start_dly ? gnd_trip_dly_start_ms : gnd_trip_dly_run_ms;
	assign gnd_alarm_dly = use_start_dly ? gnd_alarm_dly_start_ms : gnd_alarm_dly_run_ms;

	assign unb_trip_cond = unb_trip_en && st_ff.unb_armed
		&& (st_ff.unb_pct > UNB_W'(unb_trip_pickup_pct));
	assign unb_alarm_cond = unb_alarm_en && st_ff.unb_armed
		&& (st_ff.unb_pct > UNB_W'(unb_alarm_pickup_pct));
	assign bf_cond = trip_active && (mean_phase_current >= bf_pickup)
		&& (bf_assign != MPUB_BF_OFF);
	assign gnd_trip_cond = gnd_trip_en && (ground_cur >= gnd_trip_pickup);
	assign gnd_alarm_cond = gnd_alarm_en && (ground_cur >= gnd_alarm_pickup);
	assign tc_alarm = tc_alarm_en && (tc_used_pct > tc_alarm_level_pct);

	// Unbalance trip and alarm share one delay setting
	mpub_delay #(
		.W(DLY_W)
	) u_unb_trip (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.tick(st_ff.tick),
		.cond(unb_trip_cond),
		.delay_ms(unb_delay_ms),
		.done(unb_trip_q)
	);
	mpub_delay #(
		.W(DLY_W)
	) u_unb_alarm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.tick(st_ff.tick),
		.cond(unb_alarm_cond),
		.delay_ms(unb_delay_ms),
		.done(unb_alarm_q)
	);
	// Breaker failure pickup qualifier
	mpub_delay #(
		.W(DLY_W)
	) u_bf_pick (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.tick(st_ff.tick),
		.cond(bf_cond),
		.delay_ms(bf_pickup_delay_ms),
		.done(bf_pick_q)
	);
	// Ground qualifiers, delay picked by motor state
	mpub_delay #(
		.W(DLY_W)
	) u_gnd_trip (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.tick(st_ff.tick),
		.cond(gnd_trip_cond),
		.delay_ms(gnd_trip_dly),
		.done(gnd_trip_q)
	);
	mpub_delay #(
		.W(DLY_W)
	) u_gnd_alarm (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ce(ce),
		.tick(st_ff.tick),
		.cond(gnd_alarm_cond),
		.delay_ms(gnd_alarm_dly),
		.done(gnd_alarm_q)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		unb_sum = '0;
		// Millisecond timebase
		nxt_st.tick = 1'b0;
		if (st_ff.tick_cnt == 16'(TICK_CYC - 1)) begin
			nxt_st.tick_cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.tick_cnt = st_ff.tick_cnt + 16'h0001;
		end
		// Mean of the three phases, inputs taken as unsigned
		nxt_st.mean3 = ((CUR_W+2)'(phase_a_cur) + (CUR_W+2)'(phase_b_cur)
			+ (CUR_W+2)'(phase_c_cur)) / (CUR_W+2)'(3);
		// Largest deviation from the mean
		if (da >= db && da >= dc) begin
			nxt_st.dev = da;
		end else if (db >= dc) begin
			nxt_st.dev = db;
		end else begin
			nxt_st.dev = dc;
		end
		// Suppress on light load
		nxt_st.unb_armed = (32'(mean_phase_current) * PCT_FULL)
			>= (32'(rated_load_current_setting) * LIGHT_LOAD_PCT);
		// Serial restoring divider, one quotient bit per cycle
		if (st_ff.div_step == 6'h00) begin
			nxt_st.unb_num = 32'(st_ff.dev) * PCT_FULL;
			nxt_st.unb_den = (mean_phase_current >= rated_load_current_setting)
				? (CUR_W+2)'(mean_phase_current)
				: (CUR_W+2)'(rated_load_current_setting);
			nxt_st.unb_quo = '0;
			nxt_st.unb_rem = '0;
			nxt_st.div_step = 6'h01;
		end else if (st_ff.div_step <= 6'(UNB_W)) begin
			unb_sum = {st_ff.unb_rem[UNB_W-2:0], st_ff.unb_num[UNB_W-1]};
			nxt_st.unb_num = {st_ff.unb_num[UNB_W-2:0], 1'b0};
			if (st_ff.unb_den != '0 && unb_sum >= UNB_W'(st_ff.unb_den)) begin
				nxt_st.unb_rem = unb_sum - UNB_W'(st_ff.unb_den);
				nxt_st.unb_quo = {st_ff.unb_quo[UNB_W-2:0], 1'b1};
			end else begin
				nxt_st.unb_rem = unb_sum;
				nxt_st.unb_quo = {st_ff.unb_quo[UNB_W-2:0], 1'b0};
			end
			nxt_st.div_step = st_ff.div_step + 6'h01;
		end else begin
			nxt_st.unb_pct = (st_ff.unb_den == '0) ? '0 : st_ff.unb_quo;
			nxt_st.div_step = 6'h00;
		end
		// Breaker failure: pickup then held through the dropout delay
		if (bf_pick_q) begin
			nxt_st.bf_out = 1'b1;
			nxt_st.bf_drop_cnt = '0;
		end else if (st_ff.bf_out) begin
			// Spare tick keeps the hold at least the full dropout delay
			if (bf_dropout_delay_ms == '0) begin
				nxt_st.bf_out = 1'b0;
				nxt_st.bf_drop_cnt = '0;
			end else if (st_ff.tick) begin
				if (st_ff.bf_drop_cnt >= bf_dropout_delay_ms) begin
					nxt_st.bf_out = 1'b0;
					nxt_st.bf_drop_cnt = '0;
				end else begin
					nxt_st.bf_drop_cnt = st_ff.bf_drop_cnt + 1'b1;
				end
			end
		end
		// Relays, indicators and message flags
		nxt_st.trip_relay = unb_trip_q || (gnd_trip_q && gnd_trip_relays[0]);
		nxt_st.aux_relay = (gnd_trip_q && gnd_trip_relays[1])
			|| (st_ff.bf_out && (bf_assign == MPUB_BF_AUX
			|| bf_assign == MPUB_BF_ALARM_AUX));
		nxt_st.alarm_relay = unb_alarm_q || tc_alarm || gnd_alarm_q
			|| (st_ff.bf_out && (bf_assign == MPUB_BF_ALARM
			|| bf_assign == MPUB_BF_ALARM_AUX));
		// Ground trip lights only the indicators of the selected relays
		nxt_st.trip_led = unb_trip_q || (gnd_trip_q && gnd_trip_relays[0]);
		nxt_st.aux_led = gnd_trip_q && gnd_trip_relays[1];
		nxt_st.msg = '0;
		if (unb_trip_q) begin
			nxt_st.msg = nxt_st.msg | MSG_UNB_TRIP;
		end
		if (unb_alarm_q) begin
			nxt_st.msg = nxt_st.msg | MSG_UNB_ALARM;
		end
		if (tc_alarm) begin
			nxt_st.msg = nxt_st.msg | MSG_TC_ALARM;
		end
		if (st_ff.bf_out && bf_assign != MPUB_BF_AUX && bf_assign != MPUB_BF_OFF) begin
			nxt_st.msg = nxt_st.msg | MSG_BF_ALARM;
		end
		if (gnd_trip_q) begin
			nxt_st.msg = nxt_st.msg | MSG_GND_TRIP;
		end
		if (gnd_alarm_q) begin
			nxt_st.msg = nxt_st.msg | MSG_GND_ALARM;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else if (ce) begin
			st_ff <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Outputs, all registered
	// ------------------------------------------------------------
	assign trip_relay = st_ff.trip_relay;
	assign alarm_relay = st_ff.alarm_relay;
	assign aux_relay = st_ff.aux_relay;
	assign trip_led = st_ff.trip_led;
	assign aux_led = st_ff.aux_led;
	assign msg_sel = st_ff.msg;
	assign unbalance_pct = st_ff.unb_pct;
endmodule

// ===== mpub_protect_assertions.sv
/*
 * Checker for the protection block: relays and messages against their causes.
 * Assumes one clock domain and the bind at the foot of this file.
 */
`timescale 1ns/1ps
module mpub_protect_checker import mpub_pkg::*; (
	// Clock and reset
	input wire logic clk_sys, rst_n,
	// Watched inputs
	input wire logic [CUR_W-1:0] phase_a_cur, phase_b_cur, phase_c_cur,
	input wire logic [CUR_W-1:0] ground_cur, rated_load_current_setting,
	input wire logic [CUR_W-1:0] gnd_trip_pickup, gnd_alarm_pickup,
	input wire logic unb_trip_en, tc_alarm_en, gnd_trip_en, gnd_alarm_en,
	input wire logic [PCT_W-1:0] unb_trip_pickup_pct, tc_used_pct, tc_alarm_level_pct,
	input wire mpub_bf_type bf_assign,
	// Watched outputs
	input wire logic aux_relay, alarm_relay, trip_led,
	input wire logic [MSG_W-1:0] msg_sel,
	input wire logic [UNB_W-1:0] unbalance_pct
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Light load run length
	// ------------------------------------------------------------
	// Wide sum so three full-scale phases cannot wrap
	logic [CUR_W+1:0] sum;
	logic light;
	logic [5:0] light_cnt_ff;
	assign sum = phase_a_cur + phase_b_cur + phase_c_cur;
	assign light = (sum / 3) * 100 < rated_load_current_setting * 30;
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !light) begin
			light_cnt_ff <= 6'h00;
		end else if (light_cnt_ff != 6'h3f) begin
			light_cnt_ff <= light_cnt_ff + 6'h01;
		end
	end
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	a_light_load_quiet: assert property (light_cnt_ff >= 6'h30 |-> msg_sel[1:0] == 2'b00)
		else $error("unbalance flagged under light load");
	a_unb_trip_gate: assert property (!unb_trip_en [*6] |-> !msg_sel[0])
		else $error("unbalance trip while disabled");
	a_unb_trip_strict: assert property ((unbalance_pct <= unb_trip_pickup_pct) [*6] |-> !msg_sel[0])
		else $error("unbalance trip at or below pickup");
	a_tc_alarm_fast: assert property ((tc_alarm_en && tc_used_pct > tc_alarm_level_pct) [*4]
		|-> alarm_relay && msg_sel[2])
		else $error("thermal alarm late");
	a_tc_alarm_cause: assert property (!(tc_alarm_en && tc_used_pct > tc_alarm_level_pct) [*4]
		|-> !msg_sel[2])
		else $error("thermal alarm without cause");
	a_bf_msg_gate: assert property ((bf_assign == MPUB_BF_OFF || bf_assign == MPUB_BF_AUX) [*5]
		|-> !msg_sel[3])
		else $error("breaker message without alarm assignment");
	a_gnd_trip_cause: assert property (!(gnd_trip_en && ground_cur >= gnd_trip_pickup) [*5]
		|-> !msg_sel[4])
		else $error("ground trip without cause");
	a_gnd_alarm_cause: assert property (!(gnd_alarm_en && ground_cur >= gnd_alarm_pickup) [*5]
		|-> !msg_sel[5])
		else $error("ground alarm without cause");
	cover property (msg_sel[0]);
	cover property (msg_sel[3] && aux_relay);
	cover property (msg_sel[4] && trip_led);
endmodule

bind mpub_protect mpub_protect_checker u_chk (.*);

// ===== mpub_protect_tb.sv
/*
 * Self-checking bench for the protection block, driving all ports directly.
 * Assumes the package constants and short delay settings in whole ms.
 */
`timescale 1ns/1ps
module mpub_protect_tb;
	import mpub_pkg::*;
	logic clk_sys, rst_n, ce;
	logic [CUR_W-1:0] phase_a_cur, phase_b_cur, phase_c_cur, ground_cur, rated_load_current_setting;
	logic unb_trip_en, unb_alarm_en, tc_alarm_en, trip_active, gnd_trip_en, gnd_alarm_en;
	logic [PCT_W-1:0] unb_trip_pickup_pct, unb_alarm_pickup_pct, tc_used_pct, tc_alarm_level_pct;
	logic [DLY_W-1:0] unb_delay_ms, bf_pickup_delay_ms, bf_dropout_delay_ms;
	logic [DLY_W-1:0] gnd_trip_dly_start_ms, gnd_trip_dly_run_ms;
	logic [DLY_W-1:0] gnd_alarm_dly_start_ms, gnd_alarm_dly_run_ms;
	logic [CUR_W-1:0] bf_pickup, gnd_trip_pickup, gnd_alarm_pickup;
	logic [1:0] gnd_trip_relays;
	mpub_bf_type bf_assign;
	mpub_motor_type motor_state;
	logic trip_relay, alarm_relay, aux_relay, trip_led, aux_led;
	logic [MSG_W-1:0] msg_sel;
	logic [UNB_W-1:0] unbalance_pct;
	wire [10:0] outs = {trip_relay, alarm_relay, aux_relay, trip_led, aux_led, msg_sel};
	int miscompares = 0;
	int samples_checked = 0;
	int i;
	// Phases a, b, c, rated, trip and alarm pickup, percent, trip, alarm
	int uc[5][9] = '{'{100, 100, 70, 100, 19, 20, 20, 1, 0}, '{100, 100, 70, 100, 20, 19, 20, 0, 1},
		'{100, 130, 100, 100, 17, 18, 18, 1, 0}, '{90, 90, 0, 200, 29, 29, 30, 1, 1},
		'{87, 87, 0, 200, 1, 1, -1, 0, 0}};
	mpub_protect dut (.*);
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic cmp_out(input logic [10:0] exp, input logic [10:0] mask);
		#1;
		samples_checked++;
		if ((outs & mask) !== exp) begin
			miscompares++;
			$display("mismatch at %0t: outputs %h expected %h", $time, outs & mask, exp);
		end
	endtask
	task automatic cmp_unb(input logic [UNB_W-1:0] exp);
		#1;
		samples_checked++;
		if (unbalance_pct !== exp) begin
			miscompares++;
			$display("mismatch at %0t: unbalance %0d expected %0d", $time, unbalance_pct, exp);
		end
	endtask
	task automatic set_cur(input int a, input int b, input int c, input int r);
		@(posedge clk_sys);
		phase_a_cur <= CUR_W'(a);
		phase_b_cur <= CUR_W'(b);
		phase_c_cur <= CUR_W'(c);
		rated_load_current_setting <= CUR_W'(r);
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{phase_a_cur, phase_b_cur, phase_c_cur, ground_cur, rated_load_current_setting} = '0;
		{unb_trip_en, unb_alarm_en, tc_alarm_en, trip_active, gnd_trip_en, gnd_alarm_en} = '0;
		{unb_trip_pickup_pct, unb_alarm_pickup_pct, tc_used_pct, tc_alarm_level_pct} = '0;
		{unb_delay_ms, bf_pickup_delay_ms, bf_dropout_delay_ms, gnd_trip_relays} = '0;
		{gnd_trip_dly_start_ms, gnd_trip_dly_run_ms, gnd_alarm_dly_start_ms} = '0;
		{gnd_alarm_dly_run_ms, bf_pickup, gnd_trip_pickup, gnd_alarm_pickup} = '0;
		bf_assign = MPUB_BF_OFF;
		motor_state = MPUB_MS_RUNNING;
		ce = 1'b1;
		rst_n = 1'b0;
		cyc(20);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		cmp_out(11'h000, 11'h7ff);
		@(posedge clk_sys);
		unb_trip_en <= 1'b1;
		unb_alarm_en <= 1'b1;
		for (i = 0; i < 5; i++) begin
			set_cur(uc[i][0], uc[i][1], uc[i][2], uc[i][3]);
			unb_trip_pickup_pct <= PCT_W'(uc[i][4]);
			unb_alarm_pickup_pct <= PCT_W'(uc[i][5]);
			cyc(120);
			if (uc[i][6] >= 0) begin
				cmp_unb(UNB_W'(uc[i][6]));
			end
			cmp_out({uc[i][7][0], uc[i][8][0], 7'h00, uc[i][8][0], uc[i][7][0]}, 11'h603);
		end
		set_cur(90, 90, 0, 200);
		unb_trip_en <= 1'b0;
		unb_trip_pickup_pct <= 8'h1d;
		unb_alarm_pickup_pct <= 8'h1d;
		cyc(120);
		cmp_out(11'h202, 11'h603);
		@(posedge clk_sys);
		unb_alarm_en <= 1'b0;
		tc_alarm_en <= 1'b1;
		tc_alarm_level_pct <= 8'h32;
		tc_used_pct <= 8'h32;
		cyc(8);
		cmp_out(11'h000, 11'h204);
		@(posedge clk_sys);
		tc_used_pct <= 8'h33;
		cyc(3);
		cmp_out(11'h204, 11'h204);
		set_cur(100, 100, 100, 200);
		tc_alarm_en <= 1'b0;
		trip_active <= 1'b1;
		bf_pickup <= 16'h0064;
		for (i = 0; i < 4; i++) begin
			@(posedge clk_sys);
			bf_assign <= mpub_bf_type'(i[1:0]);
			cyc(10);
			cmp_out({1'b0, i[0], i[1], 4'h0, i[0], 3'h0}, 11'h308);
		end
		@(posedge clk_sys);
		bf_pickup <= 16'h0065;
		cyc(10);
		cmp_out(11'h000, 11'h308);
		@(posedge clk_sys);
		bf_pickup <= 16'h0064;
		bf_dropout_delay_ms <= 16'h0001;
		cyc(10);
		@(posedge clk_sys);
		trip_active <= 1'b0;
		cyc(30000);
		cmp_out(11'h308, 11'h308);
		for (i = 0; i < 60000 && aux_relay !== 1'b0; i++) begin
			cyc(1);
		end
		cmp_out(11'h000, 11'h308);
		if (i == 60000) begin
			summarize();
		end
		@(posedge clk_sys);
		bf_assign <= MPUB_BF_OFF;
		gnd_trip_en <= 1'b1;
		gnd_trip_pickup <= 16'h01f4;
		ground_cur <= 16'h01f4;
		for (i = 1; i < 4; i++) begin
			@(posedge clk_sys);
			gnd_trip_relays <= i[1:0];
			cyc(10);
			cmp_out({i[0], 1'b0, i[1], i[0], i[1], 1'b0, 1'b1, 4'h0}, 11'h5d0);
		end
		@(posedge clk_sys);
		ground_cur <= 16'h01f3;
		cyc(10);
		cmp_out(11'h000, 11'h5d0);
		@(posedge clk_sys);
		gnd_trip_dly_run_ms <= 16'h0001;
		ground_cur <= 16'h01f4;
		cyc(200);
		cmp_out(11'h000, 11'h5d0);
		@(posedge clk_sys);
		motor_state <= MPUB_MS_UNDECIDED;
		cyc(10);
		cmp_out(11'h5d0, 11'h5d0);
		@(posedge clk_sys);
		gnd_alarm_en <= 1'b1;
		gnd_alarm_pickup <= 16'h01f4;
		cyc(10);
		cmp_out(11'h220, 11'h220);
		summarize();
	end
endmodule
